// ==== src/codec_ctrl_pkg.sv ====
// Overview of operation
// RULE1: select pin picks SPI or I2C slave
// RULE2: host holds slave select low per transaction
// RULE3: bits shift only on host serial clock
// RULE4: I2C works at standard and fast speeds
// RULE5: two strap pins form low address bits
// RULE6: host pulses reset low at least 10 ns
// RULE7: no register access before reset completes
// RULE8: jack insertion raises interrupt output
// RULE9: SPI mode uses third pin as data-in
// RULE10: reset low clears all control state asynchronously; the register array in codec_regmem is not reset
package codec_ctrl_pkg;
    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam int        REG_AW         = 7;
    localparam int        REG_DW         = 8;
    localparam logic      SEL_SPI        = 1'b1;
    localparam logic [6:0] JACK_IDX      = 7'h7F;
    localparam logic [4:0] I2C_BASE_ADDR = 5'h0C;
    localparam int        MCLK_MHZ       = 100;
    localparam int        RESET_MIN_NS   = 10;
    localparam int        RESET_CYC      = (RESET_MIN_NS * MCLK_MHZ + 999) / 1000;
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam logic [2:0] LAST_BIT      = 3'h7;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sel;
        logic cs_a0;
        logic a1;
        logic sin;
        logic sclk;
        logic sda;
        logic jack;
    } pins_t;

    typedef struct packed {
        logic              en;
        logic [REG_AW-1:0] addr;
        logic [REG_DW-1:0] data;
    } wr_req_t;

    typedef enum logic [3:0] {
        I_IDLE, I_ADDR, I_ADDR_ACK, I_REG, I_ACK_W, I_WDATA, I_RDATA, I_RDATA_ACK
    } i2c_st_t;
endpackage

// ==== src/codec_regmem.sv ====
`timescale 1ns/1ps
module codec_regmem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // clock
    input  wire logic          i_mclk,
    // write port
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata,
    // read port
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata
);
    if (AW < 1 || DW < 1) begin : g_bad_size
        $error("codec_regmem: bad size");
    end
    logic [DW-1:0] mem [0:(1<<AW)-1];
    // no reset on the array: contents are defaults loaded by software
    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end
    always_ff @(posedge i_mclk) begin
        o_rdata <= mem[i_raddr];
    end
endmodule // codec_regmem

// ==== src/codec_ctrl_port.sv ====
`timescale 1ns/1ps
module codec_ctrl_port #(
    parameter logic [4:0] I2C_BASE = codec_ctrl_pkg::I2C_BASE_ADDR
) (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    // straps and control pins
    input  wire logic i_bus_select_pin,
    input  wire logic i_chip_select_or_addr_bit0_pin,
    input  wire logic i_addr_bit1_pin,
    input  wire logic i_serial_in_or_alt_input_pin,
    input  wire logic i_serial_clk_pin,
    input  wire logic i_sda_in,
    output logic      o_sda_out,
    output logic      o_sda_oe,
    output logic      o_serial_out,
    output logic      o_serial_out_oe,
    // jack detect
    input  wire logic i_jack_sense_pin,
    output logic      o_jack_irq,
    // status and alternate input
    output logic      o_ctrl_ready,
    output logic      o_alt_input,
    output logic      o_alt_input_valid
);
    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    codec_ctrl_pkg::pins_t raw, s1_r, s_r, p_r;
    assign raw = '{i_bus_select_pin, i_chip_select_or_addr_bit0_pin, i_addr_bit1_pin,
                   i_serial_in_or_alt_input_pin, i_serial_clk_pin, i_sda_in, i_jack_sense_pin};
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_r <= '0;
            s_r  <= '0;
            p_r  <= '0;
        end else begin
            s1_r <= raw;
            s_r  <= s1_r;
            p_r  <= s_r;
        end
    end

    logic is_spi, ss_act, sclk_rise, sclk_fall, scl_rise, scl_fall, i2c_start, i2c_stop;
    assign is_spi    = (s_r.sel == codec_ctrl_pkg::SEL_SPI); // RULE1
    assign ss_act    = is_spi && !s_r.cs_a0; // RULE2
    assign sclk_rise = s_r.sclk && !p_r.sclk; // RULE3
    assign sclk_fall = !s_r.sclk && p_r.sclk;
    assign scl_rise  = sclk_rise;
    assign scl_fall  = sclk_fall;
    assign i2c_start = s_r.sclk && p_r.sclk && p_r.sda && !s_r.sda;
    assign i2c_stop  = s_r.sclk && p_r.sclk && !p_r.sda && s_r.sda;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [3:0] rcnt_r;
    logic       ready_r;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin // RULE10
            rcnt_r  <= '0;
            ready_r <= 1'b0;
        end else if (!ready_r) begin // RULE7
            rcnt_r  <= rcnt_r + 4'h1;
            ready_r <= (rcnt_r >= 4'(codec_ctrl_pkg::RESET_CYC));
        end
    end
    assign o_ctrl_ready = ready_r;

    // ----------------------------------------------------------------
    // register memory and read mux
    // ----------------------------------------------------------------
    logic [6:0] spi_ptr_r, i2c_ptr_r, raddr;
    logic [7:0] mem_rdata, rd_byte;
    logic       jack_flag_r, spi_ld, i2c_ld;
    codec_ctrl_pkg::wr_req_t spi_wr_r, i2c_wr_r, wr;
    assign raddr   = is_spi ? spi_ptr_r : i2c_ptr_r;
    assign wr      = is_spi ? spi_wr_r : i2c_wr_r;
    assign rd_byte = (raddr == codec_ctrl_pkg::JACK_IDX) ?
                     {6'h00, s_r.jack, jack_flag_r} : mem_rdata;

    codec_regmem #(.AW(codec_ctrl_pkg::REG_AW), .DW(codec_ctrl_pkg::REG_DW)) u_mem (
        .i_mclk  (i_mclk),
        .i_we    (wr.en),
        .i_waddr (wr.addr),
        .i_wdata (wr.data),
        .i_raddr (raddr),
        .o_rdata (mem_rdata)
    );

    // ----------------------------------------------------------------
    // spi slave, mode 0
    // ----------------------------------------------------------------
    logic [2:0] bcnt_r;
    logic [6:0] spi_sh_r;
    logic [7:0] spi_out_r;
    logic       first_r, rw_r;
    // sclk must stay below a quarter of i_mclk, so sampled edges never merge
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bcnt_r <= '0; spi_sh_r <= '0; spi_out_r <= '0; first_r <= 1'b1;
            rw_r <= 1'b0; spi_ptr_r <= '0; spi_wr_r <= '0; spi_ld <= 1'b0;
            o_serial_out <= 1'b0; o_serial_out_oe <= 1'b0;
        end else begin
            spi_wr_r.en     <= 1'b0;
            spi_ld          <= 1'b0;
            o_serial_out_oe <= ss_act && ready_r; // RULE2
            if (!ss_act || !ready_r) begin // RULE2
                bcnt_r  <= '0;
                first_r <= 1'b1;
            end else if (sclk_rise) begin // RULE3
                spi_sh_r <= {spi_sh_r[5:0], s_r.sin}; // RULE9
                bcnt_r   <= bcnt_r + 3'h1;
                if (bcnt_r == codec_ctrl_pkg::LAST_BIT) begin
                    first_r <= 1'b0;
                    if (first_r) begin
                        spi_ptr_r <= spi_sh_r;
                        rw_r      <= s_r.sin;
                    end else begin
                        spi_ptr_r <= spi_ptr_r + 7'h01;
                        spi_wr_r  <= '{!rw_r, spi_ptr_r, {spi_sh_r, s_r.sin}};
                    end
                end
            end else if (sclk_fall) begin // RULE3
                if (bcnt_r == 3'h0 && !first_r && rw_r) begin
                    spi_out_r    <= rd_byte;
                    o_serial_out <= rd_byte[7];
                    spi_ld       <= 1'b1;
                end else begin
                    spi_out_r    <= {spi_out_r[6:0], 1'b0};
                    o_serial_out <= spi_out_r[6];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // i2c slave
    // ----------------------------------------------------------------
    codec_ctrl_pkg::i2c_st_t st_r;
    logic [3:0] icnt_r;
    logic [7:0] ish_r, iout_r;
    logic       irw_r;
    logic [6:0] my_addr;
    assign my_addr   = {I2C_BASE, s_r.a1, s_r.cs_a0}; // RULE5
    assign o_sda_out = 1'b0;
    // oversampled at 100 MHz, so 100 kHz and 400 kHz masters both fit
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= codec_ctrl_pkg::I_IDLE; icnt_r <= '0; ish_r <= '0; iout_r <= '0;
            irw_r <= 1'b0; i2c_ptr_r <= '0; i2c_wr_r <= '0; i2c_ld <= 1'b0;
            o_sda_oe <= 1'b0;
        end else begin
            i2c_wr_r.en <= 1'b0;
            i2c_ld      <= 1'b0;
            if (is_spi || !ready_r) begin // RULE1
                st_r     <= codec_ctrl_pkg::I_IDLE;
                o_sda_oe <= 1'b0;
            end else if (i2c_start) begin // RULE4
                st_r     <= codec_ctrl_pkg::I_ADDR;
                icnt_r   <= '0;
                o_sda_oe <= 1'b0;
            end else if (i2c_stop) begin
                st_r     <= codec_ctrl_pkg::I_IDLE;
                o_sda_oe <= 1'b0;
            end else begin
                if (scl_rise) begin
                    ish_r  <= {ish_r[6:0], s_r.sda};
                    icnt_r <= icnt_r + 4'h1;
                end
                case (st_r)
                    codec_ctrl_pkg::I_ADDR, codec_ctrl_pkg::I_REG,
                    codec_ctrl_pkg::I_WDATA: begin
                        if (scl_fall && icnt_r == codec_ctrl_pkg::BYTE_BITS) begin
                            o_sda_oe <= 1'b1;
                            st_r     <= codec_ctrl_pkg::I_ACK_W;
                            if (st_r == codec_ctrl_pkg::I_ADDR) begin
                                irw_r <= ish_r[0];
                                st_r  <= codec_ctrl_pkg::I_ADDR_ACK;
                                if (ish_r[7:1] != my_addr) begin // RULE5
                                    o_sda_oe <= 1'b0;
                                    st_r     <= codec_ctrl_pkg::I_IDLE;
                                end
                            end else if (st_r == codec_ctrl_pkg::I_REG) begin
                                i2c_ptr_r <= ish_r[6:0];
                            end else begin
                                i2c_wr_r  <= '{1'b1, i2c_ptr_r, ish_r};
                                i2c_ptr_r <= i2c_ptr_r + 7'h01;
                            end
                        end
                    end
                    codec_ctrl_pkg::I_ADDR_ACK, codec_ctrl_pkg::I_ACK_W: begin
                        if (scl_fall) begin
                            icnt_r   <= '0;
                            o_sda_oe <= 1'b0;
                            if (st_r == codec_ctrl_pkg::I_ACK_W) begin
                                st_r <= codec_ctrl_pkg::I_WDATA;
                            end else if (irw_r) begin
                                st_r     <= codec_ctrl_pkg::I_RDATA;
                                iout_r   <= rd_byte;
                                o_sda_oe <= !rd_byte[7];
                                i2c_ld   <= 1'b1;
                            end else begin
                                st_r <= codec_ctrl_pkg::I_REG;
                            end
                        end
                    end
                    codec_ctrl_pkg::I_RDATA: begin
                        if (scl_fall && icnt_r == codec_ctrl_pkg::BYTE_BITS) begin
                            o_sda_oe  <= 1'b0;
                            st_r      <= codec_ctrl_pkg::I_RDATA_ACK;
                            i2c_ptr_r <= i2c_ptr_r + 7'h01;
                        end else if (scl_fall) begin
                            iout_r   <= {iout_r[6:0], 1'b0};
                            o_sda_oe <= !iout_r[6];
                        end
                    end
                    codec_ctrl_pkg::I_RDATA_ACK: begin
                        if (scl_rise && s_r.sda) begin
                            st_r <= codec_ctrl_pkg::I_IDLE;
                        end else if (scl_fall) begin
                            icnt_r   <= '0;
                            st_r     <= codec_ctrl_pkg::I_RDATA;
                            iout_r   <= rd_byte;
                            o_sda_oe <= !rd_byte[7];
                            i2c_ld   <= 1'b1;
                        end
                    end
                    default: st_r <= codec_ctrl_pkg::I_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // jack detect and alternate input
    // ----------------------------------------------------------------
    logic jack_clr;
    assign jack_clr = (spi_ld || i2c_ld) && (raddr == codec_ctrl_pkg::JACK_IDX);
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            jack_flag_r <= 1'b0;
        end else if (ready_r && s_r.jack && !p_r.jack) begin // RULE8
            jack_flag_r <= 1'b1;
        end else if (jack_clr) begin
            jack_flag_r <= 1'b0;
        end
    end
    assign o_jack_irq = jack_flag_r;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_alt_input       <= 1'b0;
            o_alt_input_valid <= 1'b0;
        end else begin
            // select pin is not settled until ready, so the alternate input waits too
            o_alt_input       <= (is_spi || !ready_r) ? 1'b0 : s_r.sin; // RULE9
            o_alt_input_valid <= !is_spi && ready_r;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_spi_quiet; !ss_act |=> !o_serial_out_oe; endproperty
    a_spi_quiet: assert property (p_spi_quiet) else $error("miso driven w/o select"); // RULE2
    property p_i2c_no_sda; is_spi |=> !o_sda_oe; endproperty
    a_i2c_no_sda: assert property (p_i2c_no_sda) else $error("sda driven in spi"); // RULE1
    property p_shift; ss_act && ready_r && sclk_rise |=> bcnt_r == $past(bcnt_r) + 3'h1;
    endproperty
    a_shift: assert property (p_shift) else $error("bit not shifted"); // RULE3
    property p_hold; ss_act && !sclk_rise |=> $stable(bcnt_r); endproperty
    a_hold: assert property (p_hold) else $error("shift without clock"); // RULE3
    property p_nomatch; st_r == codec_ctrl_pkg::I_ADDR && scl_fall && !is_spi && !i2c_start
        && !i2c_stop && icnt_r == codec_ctrl_pkg::BYTE_BITS && ish_r[7:1] != my_addr
        |=> st_r == codec_ctrl_pkg::I_IDLE && !o_sda_oe;
    endproperty
    a_nomatch: assert property (p_nomatch) else $error("acked wrong address"); // RULE5
    property p_ack; st_r == codec_ctrl_pkg::I_ADDR_ACK |-> o_sda_oe; endproperty
    a_ack: assert property (p_ack) else $error("address ack missing"); // RULE4
    property p_ready; !ready_r |-> !wr.en && !o_serial_out_oe; endproperty
    a_ready: assert property (p_ready) else $error("access before ready"); // RULE7
    property p_jack; ready_r && s_r.jack && !p_r.jack |=> o_jack_irq; endproperty
    a_jack: assert property (p_jack) else $error("jack irq lost"); // RULE8
    property p_alt; is_spi |=> !o_alt_input_valid && !o_alt_input; endproperty
    a_alt: assert property (p_alt) else $error("alt input live in spi"); // RULE9
    c_spi_wr: cover property (spi_wr_r.en);
    c_i2c_wr: cover property (i2c_wr_r.en);
    c_i2c_rd: cover property (i2c_ld);
    c_jack: cover property (o_jack_irq ##1 !o_jack_irq);
endmodule // codec_ctrl_port

// ==== test/host_model.sv ====
`timescale 1ns/1ps
module host_model (
    // clock and wire levels
    input  wire logic i_mclk,
    input  wire logic i_sda_wire,
    input  wire logic i_miso,
    input  wire logic i_miso_oe,
    // pins driven by the host
    output logic      o_sel,
    output logic      o_cs_a0,
    output logic      o_a1,
    output logic      o_sin,
    output logic      o_sclk,
    output logic      o_sda_pull
);
    int   half = 5;
    logic last = 1'b0;
    initial begin
        {o_sel, o_cs_a0, o_a1, o_sin, o_sclk, o_sda_pull} = 6'b110000;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // spi idles with clock low, i2c with clock and data high
    task automatic set_mode(input logic spi, input logic b1, input logic b0);
        if (spi) begin
            o_cs_a0 = 1'b1;
            o_sel   = 1'b1;
            wait_n(4);
            o_sclk  = 1'b0;
        end else begin
            o_sclk     = 1'b1;
            o_sda_pull = 1'b0;
            o_sel      = 1'b0;
            o_a1       = b1;
            o_cs_a0    = b0;
        end
        wait_n(8);
    endtask
    // ----------------------------------------------------------------
    // spi master, mode 0, msb first
    // ----------------------------------------------------------------
    task automatic spi_xfer(input logic [15:0] sh, input logic sel, output logic [7:0] rd);
        rd      = 8'h00;
        o_cs_a0 = ~sel;
        wait_n(half);
        for (int i = 15; i >= 0; i--) begin
            o_sin  = sh[i];
            wait_n(half);
            // released miso shows the inverse so stale data never matches
            last   = i_miso_oe ? i_miso : ~last;
            rd     = {rd[6:0], last};
            o_sclk = 1'b1;
            wait_n(half);
            o_sclk = 1'b0;
        end
        wait_n(half);
        o_cs_a0 = 1'b1;
        wait_n(half);
    endtask
    // ----------------------------------------------------------------
    // i2c master; data moves half/2 mclk cycles after scl falls, a fifth of the 2.5*half period
    // ----------------------------------------------------------------
    task automatic i2c_bit(input logic b, output logic s);
        wait_n(half / 2);
        o_sda_pull = ~b;
        wait_n(half);
        o_sclk     = 1'b1;
        wait_n(half);
        s          = i_sda_wire;
        o_sclk     = 1'b0;
    endtask
    task automatic i2c_byte(input logic [7:0] b, output logic [7:0] got);
        logic s;
        got = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(b[i], s);
            got = {got[6:0], s};
        end
    endtask
    task automatic i2c_write(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                             input logic wdat, output logic ack);
        logic [7:0] g;
        logic       s;
        o_sda_pull = 1'b1;
        wait_n(half);
        o_sclk = 1'b0;
        i2c_byte({dev, 1'b0}, g);
        i2c_bit(1'b1, s);
        ack = ~s;
        if (ack) begin
            i2c_byte(ra, g);
            i2c_bit(1'b1, s);
            if (wdat) begin
                i2c_byte(d, g);
                i2c_bit(1'b1, s);
            end
        end
        wait_n(half / 2);
        o_sda_pull = 1'b1;
        wait_n(half);
        o_sclk = 1'b1;
        wait_n(half);
        o_sda_pull = 1'b0;
        wait_n(half);
    endtask
    task automatic i2c_read(input logic [6:0] dev, output logic [7:0] d, output logic [7:0] d2);
        logic s;
        o_sda_pull = 1'b1;
        wait_n(half);
        o_sclk = 1'b0;
        i2c_byte({dev, 1'b1}, d);
        i2c_bit(1'b1, s);
        i2c_byte(8'hFF, d);
        // master ack asks for the next byte, the final nack ends the burst
        i2c_bit(1'b0, s);
        i2c_byte(8'hFF, d2);
        i2c_bit(1'b1, s);
        wait_n(half / 2);
        o_sda_pull = 1'b1;
        wait_n(half);
        o_sclk = 1'b1;
        wait_n(half);
        o_sda_pull = 1'b0;
        wait_n(half);
    endtask
endmodule // host_model

// ==== test/tb_codec_ctrl_port.sv ====
`timescale 1ns/1ps
module tb_codec_ctrl_port;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_jack_sense_pin = 1'b0;
    logic        sel, cs_a0, a1, sin, sclk, pull, ack;
    logic        o_sda_out, o_sda_oe, o_serial_out, o_serial_out_oe;
    logic        o_jack_irq, o_ctrl_ready, o_alt_input, o_alt_input_valid;
    logic [31:0] seed = 32'hBF11;
    logic [7:0]  mem [128];
    logic [7:0]  rd, v;
    logic [6:0]  ra;
    int          fails = 0;
    int          cmp_count = 0;
    wire logic   sda_wire = ~(pull | o_sda_oe);
    always #5 i_mclk = ~i_mclk;
    codec_ctrl_port dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus_select_pin(sel),
        .i_chip_select_or_addr_bit0_pin(cs_a0), .i_addr_bit1_pin(a1),
        .i_serial_in_or_alt_input_pin(sin), .i_serial_clk_pin(sclk), .i_sda_in(sda_wire),
        .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_serial_out(o_serial_out),
        .o_serial_out_oe(o_serial_out_oe), .i_jack_sense_pin(i_jack_sense_pin),
        .o_jack_irq(o_jack_irq), .o_ctrl_ready(o_ctrl_ready), .o_alt_input(o_alt_input),
        .o_alt_input_valid(o_alt_input_valid));
    host_model host_u (.i_mclk(i_mclk), .i_sda_wire(sda_wire), .i_miso(o_serial_out),
        .i_miso_oe(o_serial_out_oe), .o_sel(sel), .o_cs_a0(cs_a0), .o_a1(a1), .o_sin(sin),
        .o_sclk(sclk), .o_sda_pull(pull));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [6:0] dev_addr(input logic [1:0] st);
        return {codec_ctrl_pkg::I2C_BASE_ADDR, st};
    endfunction
    task automatic rnd(output logic [7:0] r);
        seed = xs(seed);
        r    = seed[7:0];
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_flag(input int which);
        for (int i = 0; i < 40; i++) begin
            if ((which == 0 ? o_ctrl_ready : o_jack_irq) === 1'b1) return;
            @(negedge i_mclk);
        end
        fails++;
        $display("BAD flag %0d expected 1 seen 0", which);
        wrap_up();
    endtask
    task automatic spi_rd(input logic [6:0] a, input logic [7:0] exp, input string what);
        host_u.spi_xfer({a, 1'b1, 8'h00}, 1'b1, rd);
        chk(what, rd, exp);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(negedge i_mclk);
        chk("ready in reset", o_ctrl_ready, 8'h00);
        chk("sda oe in reset", o_sda_oe, 8'h00);
        chk("irq in reset", o_jack_irq, 8'h00);
        i_rst_n = 1'b1;
        wait_flag(0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            rnd(v);
            ra = (v[6:0] == codec_ctrl_pkg::JACK_IDX) ? 7'h10 : v[6:0];
            rnd(v);
            mem[ra] = v;
            host_u.spi_xfer({ra, 1'b0, v}, 1'b1, rd);
            spi_rd(ra, mem[ra], "spi write read");
        end
        host_u.spi_xfer({ra, 1'b0, ~mem[ra]}, 1'b0, rd);
        spi_rd(ra, mem[ra], "deselected write");
        chk("miso oe deselected", o_serial_out_oe, 8'h00);
        chk("alt valid in spi", o_alt_input_valid, 8'h00);
        $display("test spi done");
        i_jack_sense_pin = 1'b1;
        wait_flag(1);
        spi_rd(codec_ctrl_pkg::JACK_IDX, 8'h03, "jack status");
        chk("irq after read", o_jack_irq, 8'h00);
        spi_rd(codec_ctrl_pkg::JACK_IDX, 8'h02, "jack present");
        i_jack_sense_pin = 1'b0;
        $display("test jack done");
        // standard speed costs four times the cycles, so it gets one write
        host_u.set_mode(1'b0, 1'b0, 1'b0);
        host_u.half = 400;
        rnd(v);
        mem[7'h30] = v;
        host_u.i2c_write(dev_addr(2'b00), 8'h30, v, 1'b1, ack);
        chk("standard ack", ack, 8'h01);
        host_u.half = 100;
        for (int s = 0; s < 4; s++) begin
            host_u.set_mode(1'b0, s[1], s[0]);
            rnd(v);
            mem[{5'h08, s[1:0]}] = v;
            host_u.i2c_write(dev_addr(s[1:0]), {6'h08, s[1:0]}, v, 1'b1, ack);
            chk("strap ack", ack, 8'h01);
            host_u.i2c_write(dev_addr(~s[1:0]), 8'h00, v, 1'b0, ack);
            chk("foreign nack", ack, 8'h00);
            host_u.o_sin = v[7];
            repeat (6) @(negedge i_mclk);
            chk("alt input", {o_alt_input_valid, o_alt_input}, {1'b1, v[7]});
        end
        host_u.i2c_write(dev_addr(2'b11), 8'h22, 8'h00, 1'b0, ack);
        chk("pointer ack", ack, 8'h01);
        host_u.i2c_read(dev_addr(2'b11), rd, v);
        chk("fast read", rd, mem[7'h22]);
        chk("fast read burst", v, mem[7'h23]);
        chk("sda drive level", o_sda_out, 8'h00);
        host_u.set_mode(1'b1, 1'b0, 1'b0);
        spi_rd(7'h30, mem[7'h30], "standard write");
        for (int s = 0; s < 3; s++) begin
            spi_rd({5'h08, s[1:0]}, mem[{5'h08, s[1:0]}], "strap write");
        end
        $display("test i2c done");
        i_jack_sense_pin = 1'b1;
        wait_flag(1);
        #2 i_rst_n = 1'b0;
        #1 chk("irq async clear", o_jack_irq, 8'h00);
        chk("ready async clear", o_ctrl_ready, 8'h00);
        repeat (2) @(negedge i_mclk);
        i_rst_n = 1'b1;
        wait_flag(0);
        $display("test second reset done");
        wrap_up();
    end
endmodule // tb_codec_ctrl_port
